//--- hw/itvl_defines.svh
// Constants of the isolation trip voting logic: sizes, input indices and register map.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ITVL_DEFINES_SVH
`define ITVL_DEFINES_SVH

`define ITVL_NDIV        4
`define ITVL_NVAR        8
`define ITVL_NMOV        12

`define ITVL_VAR_LOWLOW  0
`define ITVL_VAR_DWPRESS 1
`define ITVL_VAR_MSLFLOW 2
`define ITVL_VAR_MSLTEMP 3
`define ITVL_VAR_CONDVAC 4
`define ITVL_VAR_TURBIN  5
`define ITVL_VAR_LOWEST  6
`define ITVL_VAR_AREATMP 7

`define ITVL_MOV_HRIN_A  0
`define ITVL_MOV_HROUT_A 3
`define ITVL_MOV_TCIN    6
`define ITVL_MOV_TCOUT   7
`define ITVL_MOV_WCIN    8
`define ITVL_MOV_WCOUT   9
`define ITVL_MOV_SDC     10
`define ITVL_MOV_HSPRAY  11

`define ITVL_ADDR_W      8
`define ITVL_REG_CTRL    8'h00
`define ITVL_REG_STATUS  8'h04
`define ITVL_REG_CHAN    8'h08
`define ITVL_CTRL_TEST   0
`define ITVL_CTRL_ALMEN  1
`define ITVL_CTRL_RST    2'h2

`endif

//--- hw/itvl_pkg.sv
// Types and shared functions of the isolation trip voting logic.
// Assumes the defines header is on the include path.
`default_nettype none
`include "itvl_defines.svh"
package itvl_pkg;
  typedef logic [`ITVL_NDIV-1:0] itvl_div_t;
  typedef enum logic [1:0] {PR_IDLE, PR_WITHDRAW, PR_CLOSED} itvl_probe_state_t;

  function automatic logic itvl_two_of(input itvl_div_t v);
    int n;
    n = 0;
    for (int i = 0; i < `ITVL_NDIV; i++) begin
      n += int'(v[i]);
    end
    return n >= 2;
  endfunction : itvl_two_of
endpackage : itvl_pkg
`default_nettype wire

//--- hw/itvl_vote_if.sv
// Bundle between the top logic and the channel voter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface itvl_vote_if #(parameter int NVAR = 8);
  logic [NVAR*4-1:0] chan;
  logic [3:0]        divByp;
  logic [NVAR-1:0]   varByp;
  logic [NVAR-1:0]   varTrip;
  modport voter (input chan, input divByp, input varByp, output varTrip);
  modport owner (output chan, output divByp, output varByp, input varTrip);
endinterface : itvl_vote_if
`default_nettype wire

//--- hw/itvl_vote.sv
// Two-out-of-four voter over every monitored variable.
// Assumes synchronised channel trips; a bypassed division drops its channel.
`timescale 1ns/1ps
`default_nettype none
module itvl_vote #(
  parameter int NVAR = 8
) (
  itvl_vote_if.voter vif
);
  import itvl_pkg::*;

  // With one division bypassed, the remaining three vote two out of three.
  always_comb begin
    for (int v = 0; v < NVAR; v++) begin
      vif.varTrip[v] = !vif.varByp[v] && itvl_two_of(vif.chan[v*4 +: 4] & ~vif.divByp); // R10 R22
    end
  end
endmodule : itvl_vote
`default_nettype wire

//--- hw/itvl_top.sv
// Isolation trip voting logic: voting, trip latches, valve commands and alarms.
// Assumes inputs synchronous to clk; solenoid valve outputs are high to hold a valve open.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "itvl_defines.svh"
// Function
// R1: Outboard heat removal valves from divisions two,three,one.
// R2: Cooling loop inboard division one, outboard two.
// R3: Lowest level or drywell pressure withdraws probes.
// R4: Manual command isolates all automatic valves.
// R5: Trip overrides individual valve open switches.
// R6: Trips latch; reset ignored while cause present.
// R7: No reopening before trip logic reset.
// R8: Four keylocked divisional bypass inputs.
// R9: At most one division bypassed.
// R10: Bypass turns vote into two-of-three.
// R11: Same bypass removes protection system channels.
// R12: Turbine inlet pressure bypassed outside run.
// R13: Keylocked condenser vacuum startup bypass.
// R14: Vacuum bypassed at low dome pressure/valve.
// R15: Steam isolation needs per-division pushbuttons.
// R16: Motor valves seal in until full travel.
// R17: Solenoid outputs high hold valves open.
// R18: Alarm and indication outputs provided.
// R19: Alarm outputs are strictly one-directional.
// R20: Poison injection start isolates cleanup loop.
// R21: High reactor pressure inhibits opening, no trip.
// R22: Every channel feeds all divisional votes.
// R23: Two solenoids per steam valve, both drop.
// R24: Drain valves close on paired divisions.
// R25: All isolation outputs are fail-safe.
// R26: Second bypass request rejected, first kept.
// R27: All discrete inputs synchronised first.
module itvl_top #(
  parameter logic [`ITVL_NMOV-1:0] THROTTLE_MASK = 12'h000
) (
  input  wire  logic                          clk,
  input  wire  logic                          sys_rst,
  input  wire  logic [`ITVL_ADDR_W-1:0]       regAddr,
  input  wire  logic [31:0]                   regWdata,
  input  wire  logic                          regWr,
  input  wire  logic                          regRd,
  output logic [31:0]                         regRdata,
  input  wire  logic [`ITVL_NVAR*4-1:0]       chanTrip,
  input  wire  itvl_pkg::itvl_div_t           divBypassKey,
  input  wire  logic                          modeRun,
  input  wire  logic                          condVacBypassKey,
  input  wire  logic                          domePressLow,
  input  wire  logic                          stopValveBelow90,
  input  wire  itvl_pkg::itvl_div_t           manualMslPb,
  input  wire  logic                          manualSysIso,
  input  wire  logic                          logicReset,
  input  wire  logic                          poisonStart,
  input  wire  logic                          reactorPressHigh,
  input  wire  logic [`ITVL_NMOV-1:0]         movOpenSw,
  input  wire  logic [`ITVL_NMOV-1:0]         movCloseSw,
  input  wire  logic [`ITVL_NMOV-1:0]         movLimitOpen,
  input  wire  logic [`ITVL_NMOV-1:0]         movLimitClosed,
  input  wire  logic                          msivOpenSw,
  input  wire  logic [1:0]                    drainOpenSw,
  input  wire  logic                          probeWithdrawn,
  input  wire  itvl_pkg::itvl_div_t           logicFault,
  input  wire  itvl_pkg::itvl_div_t           powerFail,
  output logic                                msivSolA,
  output logic                                msivSolB,
  output logic [1:0]                          drainSolHold,
  output logic [`ITVL_NMOV-1:0]               movOpenCmd,
  output logic [`ITVL_NMOV-1:0]               movCloseCmd,
  output logic                                probeIsoReq,
  output logic                                ballValveHold,
  output logic                                purgeValveHold,
  output itvl_pkg::itvl_div_t                 rpsChanBypass,
  output logic [7:0]                          alarmOut,
  output logic                                bypassReject
);
  import itvl_pkg::*;

  localparam int NV = `ITVL_NVAR;
  localparam int NM = `ITVL_NMOV;
  localparam int SW = NV*4 + 4*4 + 8 + NM*4 + 1 + 2 + 1;

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [NV*4-1:0] chanS;
  itvl_div_t keyS, pbS, faultS, pwrS;
  logic modeRunS, cvKeyS, domeLowS, svLowS, sysIsoS, resetS, poisonS, pressHighS;
  logic [NM-1:0] openSwS, closeSwS, limOpenS, limClosedS;
  logic msivSwS, withdrawnS;
  logic [1:0] drainSwS;

  // Two-stage synchroniser; only the second stage is decoded.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {chanTrip, divBypassKey, modeRun, condVacBypassKey, domePressLow, // R27
                  stopValveBelow90, manualMslPb, manualSysIso, logicReset, poisonStart,
                  reactorPressHigh, movOpenSw, movCloseSw, movLimitOpen, movLimitClosed,
                  msivOpenSw, drainOpenSw, probeWithdrawn, logicFault, powerFail};
      sync2_q <= sync1_q;
    end
  end
  assign {chanS, keyS, modeRunS, cvKeyS, domeLowS, svLowS, pbS, sysIsoS, resetS, poisonS,
          pressHighS, openSwS, closeSwS, limOpenS, limClosedS, msivSwS, drainSwS,
          withdrawnS, faultS, pwrS} = sync2_q;

  // Divisional bypass: first key wins, later keys are refused.
  itvl_div_t divByp_q, grant;
  always_comb begin
    grant = divByp_q;
    if (divByp_q == '0) begin
      grant = keyS & (~keyS + 4'h1); // R9
    end else if ((divByp_q & keyS) == '0) begin
      grant = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divByp_q     <= '0;
      bypassReject <= 1'b0;
    end else begin
      divByp_q     <= grant; // R8 R9
      bypassReject <= |(keyS & ~grant); // R26
    end
  end

  itvl_vote_if #(.NVAR(NV)) vif ();
  logic [NV-1:0] varTrip;
  always_comb begin
    vif.chan   = chanS; // R22
    vif.divByp = divByp_q; // R10
    vif.varByp = '0;
    vif.varByp[`ITVL_VAR_TURBIN]  = !modeRunS; // R12
    vif.varByp[`ITVL_VAR_CONDVAC] = cvKeyS || domeLowS || svLowS; // R13 R14
  end
  assign varTrip = vif.varTrip;
  itvl_vote #(.NVAR(NV)) itvl_vote_inst (.vif(vif));

  // Initiating signals per division; votes are the same in every division.
  logic mslVote, procVote, probeInit;
  itvl_div_t mslInit, procInit;
  assign mslVote  = varTrip[`ITVL_VAR_LOWLOW] || varTrip[`ITVL_VAR_MSLFLOW] ||
                    varTrip[`ITVL_VAR_MSLTEMP] || varTrip[`ITVL_VAR_CONDVAC] ||
                    varTrip[`ITVL_VAR_TURBIN];
  assign procVote = varTrip[`ITVL_VAR_DWPRESS] || varTrip[`ITVL_VAR_LOWEST] ||
                    varTrip[`ITVL_VAR_AREATMP];
  assign probeInit = varTrip[`ITVL_VAR_LOWEST] || varTrip[`ITVL_VAR_DWPRESS]; // R3
  assign mslInit  = {4{mslVote || sysIsoS}} | pbS; // R4 R15
  assign procInit = {4{procVote || sysIsoS}}; // R4

  // Trip latches; an active cause keeps its latch set through a reset.
  itvl_div_t mslTrip_q, procTrip_q;
  logic poison_q, probeIso_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mslTrip_q  <= '0;
      procTrip_q <= '0;
      poison_q   <= 1'b0;
      probeIso_q <= 1'b0;
    end else begin
      mslTrip_q  <= mslInit | (mslTrip_q & {4{!resetS}}); // R6
      procTrip_q <= procInit | (procTrip_q & {4{!resetS}}); // R6
      poison_q   <= poisonS || (poison_q && !resetS); // R20
      probeIso_q <= probeInit || (probeIso_q && !resetS); // R6
    end
  end

  // Isolation demand per motor-operated valve.
  logic [NM-1:0] isoMov, inhibitMov;
  always_comb begin
    isoMov = '0;
    for (int k = 0; k < 3; k++) begin
      isoMov[`ITVL_MOV_HRIN_A + k]  = procTrip_q[k];
      isoMov[`ITVL_MOV_HROUT_A + k] = procTrip_q[(k + 1) % 3]; // R1
    end
    isoMov[`ITVL_MOV_TCIN]   = procTrip_q[0]; // R2
    isoMov[`ITVL_MOV_TCOUT]  = procTrip_q[1]; // R2
    isoMov[`ITVL_MOV_WCIN]   = procTrip_q[0] || poison_q; // R20
    isoMov[`ITVL_MOV_WCOUT]  = procTrip_q[1] || poison_q; // R20
    isoMov[`ITVL_MOV_SDC]    = procTrip_q[1];
    isoMov[`ITVL_MOV_HSPRAY] = procTrip_q[0];
    inhibitMov = '0;
    inhibitMov[`ITVL_MOV_SDC]    = pressHighS; // R21
    inhibitMov[`ITVL_MOV_HSPRAY] = pressHighS; // R21
  end

  // Travel seal-in; trips force close and block any open request.
  logic [NM-1:0] closeSeal_q, openSeal_q, closeReq, openReq;
  assign closeReq = isoMov | closeSwS; // R5
  assign openReq  = openSwS & ~closeReq & ~inhibitMov; // R5 R7 R21
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      closeSeal_q <= '0;
      openSeal_q  <= '0;
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (THROTTLE_MASK[i]) begin
          closeSeal_q[i] <= closeReq[i];
          openSeal_q[i]  <= openReq[i];
        end else begin
          closeSeal_q[i] <= closeReq[i] || (closeSeal_q[i] && !limClosedS[i]); // R16
          openSeal_q[i]  <= !closeReq[i] && !inhibitMov[i] &&
                            (openReq[i] || (openSeal_q[i] && !limOpenS[i])); // R16
        end
      end
    end
  end
  assign movCloseCmd = closeSeal_q;
  assign movOpenCmd  = openSeal_q;

  // Solenoid pneumatic valves: energised holds open, so losing drive isolates.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msivSolA     <= 1'b0;
      msivSolB     <= 1'b0;
      drainSolHold <= 2'h0;
    end else begin
      msivSolA        <= msivSwS && !itvl_two_of(mslTrip_q); // R17 R23 R25
      msivSolB        <= msivSwS && !itvl_two_of(mslTrip_q); // R23
      drainSolHold[0] <= drainSwS[0] && !(mslTrip_q[0] || mslTrip_q[3]); // R24 R25
      drainSolHold[1] <= drainSwS[1] && !(mslTrip_q[1] || mslTrip_q[2]); // R24
    end
  end

  // Probe withdrawal: withdraw first, then drop ball and purge valves.
  itvl_probe_state_t probeState_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      probeState_q <= PR_IDLE;
    end else begin
      case (probeState_q)
        PR_IDLE: begin
          if (probeIso_q) probeState_q <= PR_WITHDRAW; // R3
        end
        PR_WITHDRAW: begin
          if (withdrawnS) probeState_q <= PR_CLOSED; // R3
        end
        default: begin
          if (!probeIso_q) probeState_q <= PR_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      probeIsoReq    <= 1'b0;
      ballValveHold  <= 1'b0;
      purgeValveHold <= 1'b0;
    end else begin
      probeIsoReq    <= probeIso_q; // R3
      ballValveHold  <= probeState_q != PR_CLOSED; // R25
      purgeValveHold <= probeState_q != PR_CLOSED; // R25
    end
  end

  // Control register and one-way alarm and status outputs.
  logic [1:0] ctrl_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `ITVL_CTRL_RST;
    end else if (regWr && regAddr == `ITVL_REG_CTRL) begin
      ctrl_q <= regWdata[1:0];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= '0;
    end else if (regRd && regAddr == `ITVL_REG_CTRL) begin
      regRdata <= {30'h0, ctrl_q};
    end else if (regRd && regAddr == `ITVL_REG_STATUS) begin
      regRdata <= {16'h0, 2'h0, poison_q, probeIso_q, divByp_q, procTrip_q, mslTrip_q};
    end else if (regRd && regAddr == `ITVL_REG_CHAN) begin
      regRdata <= {24'h0, varTrip};
    end else begin
      regRdata <= '0;
    end
  end

  logic [7:0] alarm_d;
  always_comb begin
    alarm_d[0] = sysIsoS || (|pbS);
    alarm_d[1] = |chanS;
    alarm_d[2] = (|mslTrip_q) || (|procTrip_q);
    alarm_d[3] = (|faultS) || (|divByp_q);
    alarm_d[4] = (|divByp_q) || (|vif.varByp);
    alarm_d[5] = |(openSwS & isoMov) || (msivSwS && itvl_two_of(mslTrip_q));
    alarm_d[6] = ctrl_q[`ITVL_CTRL_TEST];
    alarm_d[7] = |pwrS;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarmOut      <= '0;
      rpsChanBypass <= '0;
    end else begin
      alarmOut      <= alarm_d & {8{ctrl_q[`ITVL_CTRL_ALMEN]}}; // R18 R19
      rpsChanBypass <= divByp_q; // R11
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  byp_onehot_a: assert property ($onehot0(divByp_q)) // R9
    else $error("more than one division bypassed");
  byp_keep_a: assert property ((divByp_q != '0 && (divByp_q & keyS) != '0) // R26
    |=> divByp_q == $past(divByp_q)) else $error("active bypass replaced");
  trip_latch_a: assert property ((mslTrip_q[0] && !resetS) |=> mslTrip_q[0]) // R6
    else $error("trip released without reset");
  reset_ign_a: assert property (mslInit[2] |=> mslTrip_q[2]) // R6
    else $error("reset honoured while cause present");
  steam_isolation_valve_close_a: assert property (itvl_two_of(mslTrip_q) |=> !msivSolA && !msivSolB) // R23
    else $error("steam valve held with two trips");
  drain_out_a: assert property ((mslTrip_q[0] || mslTrip_q[3]) |=> !drainSolHold[0]) // R24
    else $error("outboard drain held on trip");
  hr_outb_a: assert property (procTrip_q[0] |=> movCloseCmd[`ITVL_MOV_HROUT_A + 2] // R1
    && !movOpenCmd[`ITVL_MOV_HROUT_A + 2]) else $error("loop C outboard not closed");
  seal_hold_a: assert property ((movCloseCmd[`ITVL_MOV_TCIN] && !limClosedS[`ITVL_MOV_TCIN]) // R16
    |=> movCloseCmd[`ITVL_MOV_TCIN]) else $error("close seal dropped early");
  press_inh_a: assert property ((pressHighS && !openSeal_q[`ITVL_MOV_SDC]) // R21
    |=> !movOpenCmd[`ITVL_MOV_SDC]) else $error("valve opened at high pressure");
  manual_all_a: assert property (sysIsoS |=> (&procTrip_q) && (&mslTrip_q)) // R4
    else $error("manual isolation incomplete");
  probe_seq_a: assert property ((probeIso_q && probeState_q == PR_IDLE) // R3
    |=> probeState_q == PR_WITHDRAW ##1 ballValveHold) else $error("probe sequence wrong");

  byp_grant_c: cover property (divByp_q == '0 ##1 divByp_q != '0);
  steam_isolation_valve_shut_c: cover property (msivSolA ##1 !msivSolA && !msivSolB);
  probe_done_c: cover property (probeState_q == PR_WITHDRAW ##1 probeState_q == PR_CLOSED);
  reject_c: cover property (bypassReject);
endmodule : itvl_top
`default_nettype wire

//--- dv/itvl_valve_model.sv
// Plant model beside the isolation logic: motor valve actuators with limit switches and the probe drive.
// Assumes the logic's clock; the bench resets the plant with the logic, valves then start closed.
`timescale 1ns/1ps
`default_nettype none
module itvl_valve_model #(
  parameter int NMOV   = 12,
  parameter int TRAVEL = 4
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [NMOV-1:0] movOpenCmd,
  input  wire logic [NMOV-1:0] movCloseCmd,
  input  wire logic            probeIsoReq,
  output logic      [NMOV-1:0] movLimitOpen,
  output logic      [NMOV-1:0] movLimitClosed,
  output logic                 probeWithdrawn
);
  logic [NMOV-1:0] openPos_q;
  logic [NMOV-1:0] moving_q;
  int              travel_q [NMOV];
  int              probeCnt_q;

  // A valve moves only while commanded; a command dropped early leaves it stuck between limits.
  always_ff @(posedge clk) begin
    for (int i = 0; i < NMOV; i++) begin
      if (sys_rst) begin
        openPos_q[i] <= 1'b0;
        moving_q[i]  <= 1'b0;
        travel_q[i]  <= 0;
      end else if (movOpenCmd[i] != movCloseCmd[i] && movOpenCmd[i] != openPos_q[i]) begin
        moving_q[i] <= 1'b1;
        travel_q[i] <= travel_q[i] + 1;
        if (travel_q[i] == TRAVEL - 1) begin
          openPos_q[i] <= movOpenCmd[i];
          moving_q[i]  <= 1'b0;
          travel_q[i]  <= 0;
        end
      end
    end
  end

  assign movLimitOpen   = openPos_q & ~moving_q;
  assign movLimitClosed = ~openPos_q & ~moving_q;

  // The probes are withdrawn some cycles after the request and only while it stands.
  always_ff @(posedge clk) begin
    if (sys_rst || !probeIsoReq) begin
      probeCnt_q <= 0;
    end else if (probeCnt_q < TRAVEL) begin
      probeCnt_q <= probeCnt_q + 1;
    end
  end

  assign probeWithdrawn = (probeCnt_q == TRAVEL);
endmodule : itvl_valve_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the isolation trip voting logic with a plant model on the valve side.
// Assumes the design's default parameters and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "itvl_defines.svh"
module tb_top;
  import itvl_pkg::*;
  logic        clk, sys_rst, regWr, regRd, modeRun, condVacBypassKey, domePressLow;
  logic        stopValveBelow90, manualSysIso, logicReset, poisonStart, reactorPressHigh;
  logic        msivOpenSw, probeWithdrawn, msivSolA, msivSolB, probeIsoReq;
  logic        ballValveHold, purgeValveHold, bypassReject;
  logic [7:0]  regAddr, alarmOut;
  logic [31:0] regWdata, regRdata, chanTrip;
  logic [1:0]  drainOpenSw, drainSolHold;
  logic [11:0] movOpenSw, movCloseSw, movLimitOpen, movLimitClosed, movOpenCmd, movCloseCmd;
  itvl_div_t   divBypassKey, manualMslPb, logicFault, powerFail, rpsChanBypass;
  int          fail_count, num_checks;

  itvl_top itvl_top_inst (
    .clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .chanTrip, .divBypassKey,
    .modeRun, .condVacBypassKey, .domePressLow, .stopValveBelow90, .manualMslPb, .manualSysIso,
    .logicReset, .poisonStart, .reactorPressHigh, .movOpenSw, .movCloseSw, .movLimitOpen,
    .movLimitClosed, .msivOpenSw, .drainOpenSw, .probeWithdrawn, .logicFault, .powerFail,
    .msivSolA, .msivSolB, .drainSolHold, .movOpenCmd, .movCloseCmd, .probeIsoReq,
    .ballValveHold, .purgeValveHold, .rpsChanBypass, .alarmOut, .bypassReject
  );
  itvl_valve_model itvl_valve_model_inst (
    .clk, .sys_rst, .movOpenCmd, .movCloseCmd, .probeIsoReq, .movLimitOpen, .movLimitClosed,
    .probeWithdrawn
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Waits whole cycles, then steps past the edge so outputs have settled.
  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : run

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic regRead(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(name, exp, regRdata);
  endtask : regRead

  task automatic idle;
    chanTrip         <= '0;
    divBypassKey     <= '0;
    manualMslPb      <= '0;
    manualSysIso     <= 1'b0;
    logicReset       <= 1'b0;
    poisonStart      <= 1'b0;
    reactorPressHigh <= 1'b0;
    modeRun          <= 1'b1;
    condVacBypassKey <= 1'b0;
    domePressLow     <= 1'b0;
    stopValveBelow90 <= 1'b0;
    movOpenSw        <= '1;
    movCloseSw       <= '0;
    logicFault       <= '0;
    powerFail        <= '0;
  endtask : idle

  task automatic restart;
    @(posedge clk);
    sys_rst <= 1'b1;
    idle();
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    run(20);
  endtask : restart

  task automatic opReset;
    @(posedge clk);
    logicReset <= 1'b1;
    run(4);
    @(posedge clk);
    logicReset <= 1'b0;
    run(20);
  endtask : opReset

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial begin
    fail_count  = 0;
    num_checks  = 0;
    sys_rst     = 1'b1;
    regWr       = 1'b0;
    regRd       = 1'b0;
    regAddr     = 8'h00;
    regWdata    = 32'h0;
    msivOpenSw  = 1'b1;
    drainOpenSw = 2'h3;
    idle();
    run(2);
    chk("safe in reset", 32'h0, {msivSolA, msivSolB, drainSolHold, ballValveHold});
    @(posedge clk);
    sys_rst <= 1'b0;
    run(20);
    chk("held open", 32'hf, {msivSolA, msivSolB, drainSolHold});
    chk("valves open", 32'hfff, movLimitOpen);
    regRead("ctrl", `ITVL_REG_CTRL, 32'h2);
    regWrite(`ITVL_REG_STATUS, 32'hffff_ffff);
    regWrite(8'h10, 32'hffff_ffff);
    regRead("status", `ITVL_REG_STATUS, 32'h0);
    regRead("unmapped", 8'h10, 32'h0);
    regWrite(`ITVL_REG_CTRL, 32'h3);
    regRead("ctrl", `ITVL_REG_CTRL, 32'h3);
    @(posedge clk);
    logicFault <= 4'h2;
    powerFail  <= 4'h8;
    run(8);
    chk("alarms", 32'hc8, alarmOut);
    regWrite(`ITVL_REG_CTRL, 32'h0);
    run(4);
    chk("alarms off", 32'h0, alarmOut);
    // Steam trip with the operator reset held while the cause stands.
    restart();
    @(posedge clk);
    chanTrip   <= 32'h0000_0300;
    logicReset <= 1'b1;
    run(8);
    chk("steam trip", 32'h0, {msivSolA, msivSolB, drainSolHold});
    @(posedge clk);
    chanTrip   <= '0;
    logicReset <= 1'b0;
    run(8);
    chk("trip latched", 32'h0, {msivSolA, msivSolB, drainSolHold});
    opReset();
    chk("after reset", 32'hf, {msivSolA, msivSolB, drainSolHold});
    @(posedge clk);
    manualSysIso <= 1'b1;
    run(8);
    chk("manual alarm", 32'h25, alarmOut);
    @(posedge clk);
    manualSysIso <= 1'b0;
    run(24);
    chk("all closed", 32'hfff, movLimitClosed);
    opReset();
    chk("reopened", 32'hfff, movLimitOpen);
    for (int d = 0; d < 4; d++) begin
      restart();
      @(posedge clk);
      manualMslPb <= itvl_div_t'(1 << d);
      run(8);
      chk("one division", (d == 0 || d == 3) ? 32'he : 32'hd, {msivSolA, msivSolB, drainSolHold});
    end
    @(posedge clk);
    manualMslPb <= 4'h9;
    run(8);
    chk("two divisions", 32'h2, {msivSolA, msivSolB, drainSolHold});
    restart();
    @(posedge clk);
    divBypassKey <= 4'h4;
    run(8);
    @(posedge clk);
    divBypassKey <= 4'h5;
    run(8);
    chk("bypass kept", 32'h14, {bypassReject, rpsChanBypass});
    regRead("status bypass", `ITVL_REG_STATUS, 32'h400);
    @(posedge clk);
    chanTrip <= 32'h0000_0500;
    run(8);
    regRead("vote bypassed", `ITVL_REG_CHAN, 32'h0);
    @(posedge clk);
    chanTrip <= 32'h0000_0300;
    run(8);
    regRead("vote remaining", `ITVL_REG_CHAN, 32'h4);
    chk("bypass alarms", 32'h3e, alarmOut);
    restart();
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      chanTrip         <= 32'h0033_0000;
      modeRun          <= (k != 0);
      condVacBypassKey <= (k == 1);
      domePressLow     <= (k == 2);
      stopValveBelow90 <= (k == 3);
      run(6);
      regRead("op bypass", `ITVL_REG_CHAN, (k == 0 || k == 4 ? 32'h10 : 32'h0) | (k != 0 ? 32'h20 : 32'h0));
    end
    restart();
    @(posedge clk);
    movOpenSw  <= 12'h3ff;
    movCloseSw <= 12'hc00;
    run(20);
    @(posedge clk);
    reactorPressHigh <= 1'b1;
    movOpenSw        <= '1;
    movCloseSw       <= '0;
    run(20);
    chk("press inhibit", 32'h3ff, movLimitOpen);
    regRead("no trip", `ITVL_REG_STATUS, 32'h0);
    @(posedge clk);
    reactorPressHigh <= 1'b0;
    run(20);
    chk("press clear", 32'hfff, movLimitOpen);
    @(posedge clk);
    poisonStart <= 1'b1;
    run(4);
    @(posedge clk);
    poisonStart <= 1'b0;
    run(20);
    chk("poison", 32'hcff, movLimitOpen);
    restart();
    chk("probe idle", 32'h3, {probeIsoReq, ballValveHold, purgeValveHold});
    @(posedge clk);
    chanTrip <= 32'h0300_0000;
    run(24);
    chk("probe iso", 32'h4, {probeIsoReq, ballValveHold, purgeValveHold});
    restart();
    @(posedge clk);
    chanTrip <= 32'h0000_0030;
    run(8);
    chk("drywell probe", 32'h1, probeIsoReq);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
